// *** src/cfc_core.v ***
// Program flow control: phases, fetch pipeline, return stack and one-level shadow registers
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "cfc_defines.vh"

module cfc_core (
	// Clock and reset
	input wire clock,
	input wire sys_rst,
	// Register port
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_r,
	// Program memory
	output reg [`CFC_PC_W-1:0] pm_addr_r,
	input wire [15:0] pm_data,
	// Table transfer port
	output reg [`CFC_PC_W-1:0] tbl_addr_r,
	output reg tbl_rd_r,
	output reg tbl_wr_r,
	output reg [7:0] tbl_wdata_r,
	input wire [7:0] tbl_rdata,
	// Datapath interface
	input wire exec_skip,
	input wire pcl_add,
	input wire [7:0] pcl_offset,
	input wire [7:0] core_status,
	input wire [7:0] core_working_register,
	input wire [3:0] core_bsr,
	output reg [15:0] exec_word_r,
	output reg exec_valid_r,
	output reg [11:0] exec_lit_r,
	output reg exec_lit_vld_r,
	output reg dm_rd_r,
	output reg dm_wr_r,
	output reg restore_r,
	output reg [7:0] restore_status_r,
	output reg [7:0] restore_working_register_r,
	output reg [3:0] restore_bsr_r,
	// Interrupt request, device reset and phase output
	input wire irq_req,
	input wire irq_high,
	output reg irq_ack_r,
	output reg dev_rst_r,
	output reg [3:0] phase_r
);

// ************************************************************
// State
// ************************************************************
wire [3:0] q;
wire [`CFC_PC_W-1:0] stk_rd;
reg [`CFC_PC_W-1:0] pc_r;
reg [`CFC_PC_W-1:0] ir_addr_r;
reg [15:0] ir_r;
reg ir_valid_r;
reg pend_r;
reg pend_jmp_r;
reg pend_call_r;
reg [7:0] lit_r;
reg [`CFC_IDX_W-1:0] idx_r;
reg full_r;
reg unf_r;
reg ser_en_r;
reg [7:0] sh_status_r;
reg [7:0] sh_working_register_r;
reg [3:0] sh_bsr_r;
reg irq_pend_r;
reg irq_hi_r;
reg [`CFC_PC_W-1:0] tbl_ptr_r;
reg [7:0] tlat_r;
reg tbl_cap_r;
reg rst_req_r;

// ************************************************************
// Decode of the executing word
// ************************************************************
wire is_lit = ir_r[15:12] == `CFC_LIT_PFX;
wire is_goto = ir_r[15:8] == `CFC_OP_GOTO;
wire is_call = ir_r[15:9] == `CFC_OP_CALL;
wire is_lfsr = ir_r[15:6] == `CFC_OP_LFSR;
wire is_file_to_file_move_op = ir_r[15:12] == `CFC_OP_FILE_TO_FILE_MOVE_OP;
wire is_bra = ir_r[15:11] == `CFC_OP_BRA;
wire is_rcall = ir_r[15:11] == `CFC_OP_RCALL;
wire is_ret = ir_r[15:1] == `CFC_OP_RETURN;
wire is_interrupt_return_op = ir_r[15:1] == `CFC_OP_INTERRUPT_RETURN_OP;
wire is_return_with_literal_op = ir_r[15:8] == `CFC_OP_RETURN_WITH_LITERAL_OP;
wire is_tbl = ir_r[15:3] == `CFC_OP_TBL;
wire [`CFC_PC_W-1:0] ret_addr = ir_addr_r + `CFC_PC_STEP;
// Offset counts words, so it is doubled before adding
wire [`CFC_PC_W-1:0] rel_off = {{9{ir_r[10]}}, ir_r[10:0], 1'b0};
wire [`CFC_PC_W-1:0] abs_tgt = {ir_r[11:0], lit_r, 1'b0};
wire [`CFC_PC_W-1:0] pcl_tgt = ret_addr + {13'h0000, pcl_offset[7:1], 1'b0};
wire [`CFC_PC_W-1:0] tbl_inc = tbl_ptr_r + 21'h000001;
wire [`CFC_PC_W-1:0] tbl_dec = tbl_ptr_r - 21'h000001;

reg real_op;
reg first_op;
reg redir;
reg [`CFC_PC_W-1:0] tgt;
reg push;
reg pop;
reg [`CFC_PC_W-1:0] push_val;
reg save_sh;
reg rest_sh;
reg flush;
reg take_irq;
reg lit_use;

// ************************************************************
// Execute decision, applied on Q4
// ************************************************************
always @*
begin
	real_op = 1'b0;
	first_op = 1'b0;
	redir = 1'b0;
	tgt = ret_addr;
	push = 1'b0;
	pop = 1'b0;
	push_val = ret_addr;
	save_sh = 1'b0;
	rest_sh = 1'b0;
	flush = 1'b0;
	take_irq = 1'b0;
	lit_use = 1'b0;
	if (ir_valid_r)
	begin
		if (is_lit)
		begin
			// A literal word without its first word falls through as a no-op
			if (pend_r)
			begin
				real_op = 1'b1;
				lit_use = 1'b1;
				redir = pend_jmp_r | pend_call_r;
				tgt = abs_tgt;
				push = pend_call_r;
			end
		end
		else
		begin
			real_op = 1'b1;
			first_op = is_goto | is_call | is_lfsr | is_file_to_file_move_op;
			save_sh = is_call & ir_r[8];
			if (is_bra | is_rcall)
			begin
				redir = 1'b1;
				tgt = ret_addr + rel_off;
				push = is_rcall;
			end
			if (is_ret | is_interrupt_return_op | is_return_with_literal_op)
			begin
				redir = 1'b1;
				pop = 1'b1;
				rest_sh = (is_ret | is_interrupt_return_op) & ir_r[0];
				tgt = (idx_r == `CFC_IDX_ZERO) ? `CFC_VEC_RST : stk_rd;
			end
		end
	end
	if (real_op & exec_skip)
		flush = 1'b1;
	if (real_op & pcl_add)
	begin
		redir = 1'b1;
		tgt = pcl_tgt;
	end
	// Interrupts wait for a plain instruction boundary
	if (irq_pend_r & ~redir & ~flush & ~first_op & ~pend_r)
	begin
		take_irq = 1'b1;
		redir = 1'b1;
		tgt = irq_hi_r ? `CFC_VEC_HI : `CFC_VEC_LO;
		push = 1'b1;
		push_val = pm_addr_r;
		save_sh = 1'b1;
	end
end

// ************************************************************
// Stack bookkeeping for a push or pop this Q4
// ************************************************************
wire do4 = q[`CFC_Q4];
wire push_last = push & (idx_r == `CFC_IDX_PRELAST);
wire push_over = push & (idx_r == `CFC_IDX_LAST);
wire pop_under = pop & (idx_r == `CFC_IDX_ZERO);
wire stk_err = do4 & (push_last | push_over | pop_under);
wire stk_wr = do4 & push & ~push_over;
wire [`CFC_IDX_W-1:0] idx_inc = idx_r + 5'h01;

cfc_phase u_phase (
	.clock(clock),
	.sys_rst(sys_rst),
	.q_r(q)
);

cfc_stack_mem u_stack (
	.clock(clock),
	.wr_en(stk_wr),
	.wr_addr(idx_inc),
	.wr_data(push_val),
	.rd_addr(idx_r),
	.rd_data_r(stk_rd)
);

// ************************************************************
// Pipeline, stacks and registers
// ************************************************************
always @(posedge clock or posedge sys_rst)
begin
	if (sys_rst)
	begin
		pc_r <= `CFC_VEC_RST;
		pm_addr_r <= `CFC_VEC_RST;
		ir_addr_r <= `CFC_VEC_RST;
		ir_r <= 16'h0000;
		ir_valid_r <= 1'b0;
		pend_r <= 1'b0;
		pend_jmp_r <= 1'b0;
		pend_call_r <= 1'b0;
		lit_r <= 8'h00;
		idx_r <= `CFC_IDX_ZERO;
		full_r <= 1'b0;
		unf_r <= 1'b0;
		ser_en_r <= `CFC_CTRL_SER_RST;
		sh_status_r <= 8'h00;
		sh_working_register_r <= 8'h00;
		sh_bsr_r <= 4'h0;
		irq_pend_r <= 1'b0;
		irq_hi_r <= 1'b0;
		irq_ack_r <= 1'b0;
		tbl_ptr_r <= 21'h000000;
		tlat_r <= 8'h00;
		tbl_addr_r <= 21'h000000;
		tbl_rd_r <= 1'b0;
		tbl_wr_r <= 1'b0;
		tbl_wdata_r <= 8'h00;
		tbl_cap_r <= 1'b0;
		exec_word_r <= 16'h0000;
		exec_valid_r <= 1'b0;
		exec_lit_r <= 12'h000;
		exec_lit_vld_r <= 1'b0;
		dm_rd_r <= 1'b0;
		dm_wr_r <= 1'b0;
		restore_r <= 1'b0;
		restore_status_r <= 8'h00;
		restore_working_register_r <= 8'h00;
		restore_bsr_r <= 4'h0;
		rst_req_r <= 1'b0;
		dev_rst_r <= 1'b0;
		phase_r <= 4'h0;
		reg_rdata_r <= 8'h00;
	end
	else
	begin
		phase_r <= q;
		// Strobes are registered one clock ahead so they sit in their phase
		dm_rd_r <= q[`CFC_Q1] & ir_valid_r & ~(is_lit & ~pend_r);
		dm_wr_r <= q[`CFC_Q3] & ir_valid_r & ~(is_lit & ~pend_r);
		irq_ack_r <= 1'b0;
		restore_r <= 1'b0;
		exec_lit_vld_r <= 1'b0;
		tbl_rd_r <= 1'b0;
		tbl_wr_r <= 1'b0;
		tbl_cap_r <= tbl_rd_r;
		// Flag raised first, device reset follows one clock later
		dev_rst_r <= rst_req_r;
		rst_req_r <= 1'b0;
		if (irq_req)
		begin
			irq_pend_r <= 1'b1;
			irq_hi_r <= irq_high;
		end
		if (tbl_cap_r)
			tlat_r <= tbl_rdata;
		// Register port writes; hardware updates below take precedence
		if (reg_wr)
		begin
			case (reg_addr)
				`CFC_A_STAT:
				begin
					full_r <= full_r & reg_wdata[`CFC_STAT_FULL];
					unf_r <= unf_r & reg_wdata[`CFC_STAT_UNF];
					idx_r <= reg_wdata[4:0];
				end
				`CFC_A_CTRL: ser_en_r <= reg_wdata[0];
				`CFC_A_TBL_L: tbl_ptr_r[7:0] <= reg_wdata;
				`CFC_A_TBL_H: tbl_ptr_r[15:8] <= reg_wdata;
				`CFC_A_TBL_U: tbl_ptr_r[20:16] <= reg_wdata[4:0];
				`CFC_A_TLAT: tlat_r <= reg_wdata;
				// Holding the latch here would drop a table byte captured this clock
				default: ser_en_r <= ser_en_r;
			endcase
		end
		if (reg_rd)
		begin
			case (reg_addr)
				`CFC_A_STAT: reg_rdata_r <= {full_r, unf_r, 1'b0, idx_r};
				`CFC_A_CTRL: reg_rdata_r <= {7'h00, ser_en_r};
				`CFC_A_PCL: reg_rdata_r <= {pc_r[7:1], 1'b0};
				`CFC_A_TBL_L: reg_rdata_r <= tbl_ptr_r[7:0];
				`CFC_A_TBL_H: reg_rdata_r <= tbl_ptr_r[15:8];
				`CFC_A_TBL_U: reg_rdata_r <= {3'h0, tbl_ptr_r[20:16]};
				`CFC_A_TLAT: reg_rdata_r <= tlat_r;
				default: reg_rdata_r <= 8'h00;
			endcase
		end
		// Q1: present the fetch address and step the counter by one word
		if (q[`CFC_Q1])
		begin
			pm_addr_r <= pc_r;
			pc_r <= pc_r + `CFC_PC_STEP;
		end
		// Q4: latch the fetched word and finish the executing one
		if (do4)
		begin
			ir_r <= pm_data;
			ir_addr_r <= pm_addr_r;
			ir_valid_r <= ~(redir | flush);
			exec_word_r <= ir_r;
			exec_valid_r <= real_op;
			pend_r <= first_op;
			pend_jmp_r <= first_op & (is_goto | is_call);
			pend_call_r <= first_op & is_call;
			lit_r <= ir_r[7:0];
			if (lit_use)
			begin
				exec_lit_r <= ir_r[11:0];
				exec_lit_vld_r <= 1'b1;
			end
			if (redir)
				pc_r <= {tgt[20:1], 1'b0};
			if (take_irq)
			begin
				irq_pend_r <= irq_req;
				irq_ack_r <= 1'b1;
			end
			// Shadow is one level deep, so a later save always overwrites
			if (save_sh)
			begin
				sh_status_r <= core_status;
				sh_working_register_r <= core_working_register;
				sh_bsr_r <= core_bsr;
			end
			if (rest_sh)
			begin
				restore_r <= 1'b1;
				restore_status_r <= sh_status_r;
				restore_working_register_r <= sh_working_register_r;
				restore_bsr_r <= sh_bsr_r;
			end
			if (push & ~push_over)
				idx_r <= idx_inc;
			if (push_last | push_over)
				full_r <= 1'b1;
			if (pop & ~pop_under)
				idx_r <= idx_r - 5'h01;
			if (pop_under)
			begin
				unf_r <= 1'b1;
				idx_r <= `CFC_IDX_ZERO;
			end
			if (stk_err & ser_en_r)
			begin
				// Restart from the reset vector with flags kept
				rst_req_r <= 1'b1;
				idx_r <= `CFC_IDX_ZERO;
				pc_r <= `CFC_VEC_RST;
				ir_valid_r <= 1'b0;
				pend_r <= 1'b0;
			end
			// Without the enable, errors set the flag and skip the restart; an underflow still returns to the reset vector
			if (real_op & is_tbl & ~flush & ~redir)
			begin
				tbl_addr_r <= (ir_r[1:0] == `CFC_TBL_PRE) ? tbl_inc : tbl_ptr_r;
				tbl_rd_r <= ~ir_r[2];
				tbl_wr_r <= ir_r[2];
				tbl_wdata_r <= tlat_r;
				case (ir_r[1:0])
					`CFC_TBL_INC: tbl_ptr_r <= tbl_inc;
					`CFC_TBL_DEC: tbl_ptr_r <= tbl_dec;
					`CFC_TBL_PRE: tbl_ptr_r <= tbl_inc;
					default: tbl_ptr_r <= tbl_ptr_r;
				endcase
			end
		end
	end
end

endmodule
`default_nettype wire

// *** src/cfc_defines.vh ***
// Constants for the core stack and fetch control block
`ifndef CFC_DEFINES_VH
`define CFC_DEFINES_VH

// ************************************************************
// Widths and program counter figures
// ************************************************************
`define CFC_PC_W 21
`define CFC_IDX_W 5
`define CFC_STK_DEPTH 32
`define CFC_PC_STEP 21'h000002
`define CFC_VEC_RST 21'h000000
`define CFC_VEC_HI 21'h000008
`define CFC_VEC_LO 21'h000018
`define CFC_IDX_ZERO 5'h00
`define CFC_IDX_PRELAST 5'h1e
`define CFC_IDX_LAST 5'h1f

// ************************************************************
// Register offsets and fields
// ************************************************************
`define CFC_A_STAT 3'h0
`define CFC_A_CTRL 3'h1
`define CFC_A_PCL 3'h2
`define CFC_A_TBL_L 3'h3
`define CFC_A_TBL_H 3'h4
`define CFC_A_TBL_U 3'h5
`define CFC_A_TLAT 3'h6
`define CFC_STAT_FULL 7
`define CFC_STAT_UNF 6
`define CFC_CTRL_SER_RST 1'h1

// ************************************************************
// Instruction encodings
// ************************************************************
`define CFC_LIT_PFX 4'hf
`define CFC_OP_GOTO 8'hef
`define CFC_OP_CALL 7'h76
`define CFC_OP_LFSR 10'h3b8
`define CFC_OP_FILE_TO_FILE_MOVE_OP 4'hc
`define CFC_OP_BRA 5'h1a
`define CFC_OP_RCALL 5'h1b
`define CFC_OP_RETURN 15'h0009
`define CFC_OP_INTERRUPT_RETURN_OP 15'h0008
`define CFC_OP_RETURN_WITH_LITERAL_OP 8'h0c
`define CFC_OP_TBL 13'h0001
`define CFC_TBL_INC 2'h1
`define CFC_TBL_DEC 2'h2
`define CFC_TBL_PRE 2'h3

// ************************************************************
// Phase indices
// ************************************************************
`define CFC_Q1 0
`define CFC_Q2 1
`define CFC_Q3 2
`define CFC_Q4 3

`endif

// *** src/cfc_phase.v ***
// Quadrature phase generator: divides the clock into Q1..Q4 enables
`timescale 1ns/1ns
`default_nettype none
`include "cfc_defines.vh"

module cfc_phase (
	// Clock and reset
	input wire clock,
	input wire sys_rst,
	// One-hot phase enables
	output reg [3:0] q_r
);

// ************************************************************
// Rotating one-hot phase
// ************************************************************
always @(posedge clock or posedge sys_rst)
begin
	if (sys_rst)
		q_r <= 4'h1;
	else
		q_r <= {q_r[2:0], q_r[3]};
end

endmodule
`default_nettype wire

// *** src/cfc_stack_mem.v ***
// Return address stack storage, registered read
`timescale 1ns/1ns
`default_nettype none
`include "cfc_defines.vh"

module cfc_stack_mem (
	// Clock
	input wire clock,
	// Write side
	input wire wr_en,
	input wire [`CFC_IDX_W-1:0] wr_addr,
	input wire [`CFC_PC_W-1:0] wr_data,
	// Read side
	input wire [`CFC_IDX_W-1:0] rd_addr,
	output reg [`CFC_PC_W-1:0] rd_data_r
);

// ************************************************************
// Storage; slot zero is never written
// ************************************************************
reg [`CFC_PC_W-1:0] mem [0:`CFC_STK_DEPTH-1];

always @(posedge clock)
begin
	if (wr_en)
		mem[wr_addr] <= wr_data;
	rd_data_r <= mem[rd_addr];
end

endmodule
`default_nettype wire

// *** verif/cfc_core_chk_assertions.sv ***
// Property checker for the stack and fetch control core
`timescale 1ns/1ns
`default_nettype none
`include "cfc_defines.vh"

module cfc_core_chk (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Register port
	input wire logic [2:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_r,
	// Fetch and execute
	input wire logic [`CFC_PC_W-1:0] pm_addr_r,
	input wire logic [15:0] exec_word_r,
	input wire logic dm_rd_r,
	input wire logic dm_wr_r,
	input wire logic restore_r,
	input wire logic [7:0] restore_status_r,
	input wire logic irq_ack_r,
	input wire logic dev_rst_r,
	input wire logic [3:0] phase_r
);
	// ************************************************************
	// Properties
	// ************************************************************
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	AST_PHASE_ROT: assert property (phase_r[0] |=> phase_r[1] ##1 phase_r[2] ##1 phase_r[3] ##1 phase_r[0])
		else $error("phase sequence broken");
	AST_PC_EVEN: assert property (pm_addr_r[0] == 1'b0)
		else $error("odd fetch address");
	AST_FETCH_HOLD: assert property (!$stable(pm_addr_r) |=> $stable(pm_addr_r)[*3])
		else $error("fetch address held under four clocks");
	AST_WR_AFTER_RD: assert property (dm_wr_r |-> $past(dm_rd_r, 2))
		else $error("data write not two clocks after operand read");
	AST_VECTOR: assert property (irq_ack_r |-> ##[0:8] (pm_addr_r == `CFC_VEC_HI || pm_addr_r == `CFC_VEC_LO))
		else $error("acknowledge without vector fetch");
	AST_RESTORE_HOLD: assert property (restore_r |=> $stable(restore_status_r)[*3])
		else $error("restored status not held");
	AST_RST_TO_ZERO: assert property (dev_rst_r |=> !dev_rst_r ##[0:4] (pm_addr_r == `CFC_VEC_RST))
		else $error("device reset without reset vector");
	AST_STAT_BIT5: assert property ((reg_rd && reg_addr == `CFC_A_STAT) |=> (reg_rdata_r[5] == 1'b0))
		else $error("status bit five not zero");
	AST_EXEC_HOLD: assert property (!$stable(exec_word_r) |=> $stable(exec_word_r)[*3])
		else $error("executed word not held a full cycle");
endmodule

bind cfc_core cfc_core_chk u_chk (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .pm_addr_r(pm_addr_r), .exec_word_r(exec_word_r),
	.dm_rd_r(dm_rd_r), .dm_wr_r(dm_wr_r), .restore_r(restore_r),
	.restore_status_r(restore_status_r), .irq_ack_r(irq_ack_r), .dev_rst_r(dev_rst_r),
	.phase_r(phase_r));
`default_nettype wire

// *** verif/cfc_pm_model.sv ***
// Program memory model facing the fetch and table ports
`timescale 1ns/1ns
`default_nettype none
`include "cfc_defines.vh"

module cfc_pm_model (
	// Fetch port
	input wire logic [`CFC_PC_W-1:0] pm_addr_r,
	output logic [15:0] pm_data,
	// Table port
	input wire logic [`CFC_PC_W-1:0] tbl_addr_r,
	output logic [7:0] tbl_rdata
);
	// Only 32 words are backed; beyond them the space reads as a no-op
	logic [15:0] mem [0:31];
	assign pm_data = (pm_addr_r < 21'h000040) ? mem[pm_addr_r[5:1]] : 16'h0000;
	// Table bytes alias above the backed words, a known limitation
	assign tbl_rdata = tbl_addr_r[0] ? mem[tbl_addr_r[5:1]][15:8] : mem[tbl_addr_r[5:1]][7:0];
endmodule
`default_nettype wire

// *** verif/tb_core_stack_and_fetch_control.sv ***
// Self-checking bench for the stack and fetch control core
`timescale 1ns/1ns
`default_nettype none
`include "cfc_defines.vh"

module tb_core_stack_and_fetch_control;
	// ************************************************************
	// Signals and instances
	// ************************************************************
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0, reg_rd = 1'b0, exec_skip = 1'b0, pcl_add = 1'b0;
	logic irq_req = 1'b0, irq_high = 1'b0;
	logic [7:0] pcl_offset = 8'h00, core_status = 8'h5a, core_working_register = 8'ha5;
	logic [3:0] core_bsr = 4'h3;
	wire logic [7:0] reg_rdata_r, tbl_wdata_r, tbl_rdata, restore_status_r, restore_working_register_r;
	wire logic [`CFC_PC_W-1:0] pm_addr_r, tbl_addr_r;
	wire logic [15:0] pm_data, exec_word_r;
	wire logic [11:0] exec_lit_r;
	wire logic [3:0] restore_bsr_r, phase_r;
	wire logic tbl_rd_r, tbl_wr_r, exec_valid_r, exec_lit_vld_r, dm_rd_r, dm_wr_r;
	wire logic restore_r, irq_ack_r, dev_rst_r;
	int bad_count = 0, total_checks = 0;
	int restore_count = 0, rst_count = 0, ack_count = 0, lit_bad = 0, lit_ok = 0;

	cfc_core u_dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .pm_addr_r(pm_addr_r),
		.pm_data(pm_data), .tbl_addr_r(tbl_addr_r), .tbl_rd_r(tbl_rd_r), .tbl_wr_r(tbl_wr_r),
		.tbl_wdata_r(tbl_wdata_r), .tbl_rdata(tbl_rdata), .exec_skip(exec_skip),
		.pcl_add(pcl_add), .pcl_offset(pcl_offset), .core_status(core_status),
		.core_working_register(core_working_register), .core_bsr(core_bsr), .exec_word_r(exec_word_r),
		.exec_valid_r(exec_valid_r), .exec_lit_r(exec_lit_r), .exec_lit_vld_r(exec_lit_vld_r),
		.dm_rd_r(dm_rd_r), .dm_wr_r(dm_wr_r), .restore_r(restore_r),
		.restore_status_r(restore_status_r), .restore_working_register_r(restore_working_register_r),
		.restore_bsr_r(restore_bsr_r), .irq_req(irq_req), .irq_high(irq_high),
		.irq_ack_r(irq_ack_r), .dev_rst_r(dev_rst_r), .phase_r(phase_r));
	cfc_pm_model u_pm (.pm_addr_r(pm_addr_r), .pm_data(pm_data), .tbl_addr_r(tbl_addr_r),
		.tbl_rdata(tbl_rdata));

	always #10 clock = ~clock;

	// Event counters; one-clock pulses are easy to miss by polling
	always @(posedge clock)
	begin
		if (restore_r === 1'b1) restore_count++;
		if (dev_rst_r === 1'b1) rst_count++;
		if (irq_ack_r === 1'b1) ack_count++;
		if (exec_lit_vld_r === 1'b1 && exec_lit_r === 12'h123) lit_bad++;
		if (exec_lit_vld_r === 1'b1 && exec_lit_r === 12'h000) lit_ok++;
	end

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	task automatic reg_check(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(negedge clock);
		check(reg_rdata_r & m, e);
	endtask

	task automatic wait_pm(input logic [20:0] a);
		int n;
		n = 0;
		while (pm_addr_r !== a && n < 200)
		begin
			@(negedge clock);
			n++;
		end
	endtask

	function automatic int ev(input int k);
		return (k == 0) ? restore_count : (k == 1) ? rst_count : ack_count;
	endfunction

	task automatic wait_ev(input int k, input int old);
		int n;
		n = 0;
		while (ev(k) == old && n < 200)
		begin
			@(negedge clock);
			n++;
		end
	endtask

	task automatic close_out();
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ************************************************************
	// Tests
	// ************************************************************
	initial
	begin
		for (int i = 0; i < 32; i++) u_pm.mem[i] = 16'h0000;
		u_pm.mem[0] = 16'hed08;
		u_pm.mem[1] = 16'hf000;
		u_pm.mem[2] = 16'hf123;
		u_pm.mem[3] = 16'h0012;
		u_pm.mem[4] = 16'h0011;
		u_pm.mem[8] = 16'h0013;
		u_pm.mem[12] = 16'h0010;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		reg_check(`CFC_A_CTRL, 8'hff, 8'h01);
		reg_write(`CFC_A_CTRL, 8'h00);
		wait_pm(21'h000010);
		check(pm_addr_r, 21'h000010);
		@(posedge clock);
		core_status <= 8'h11;
		core_working_register <= 8'h22;
		core_bsr <= 4'h4;
		// Park the core in a short loop once the underflow sends it home
		u_pm.mem[0] = 16'h0000;
		u_pm.mem[1] = 16'hd7fe;
		wait_ev(0, 0);
		check({restore_status_r, restore_working_register_r, restore_bsr_r}, 20'h5aa53);
		wait_pm(21'h000000);
		repeat (8) @(negedge clock);
		check(restore_count, 1);
		check(rst_count, 0);
		check(lit_bad, 0);
		check(lit_ok != 0, 1);
		for (int i = 0; i < 24; i++)
		begin
			@(negedge clock);
			check(pm_addr_r <= 21'h000004, 1);
		end
		reg_check(`CFC_A_STAT, 8'hff, 8'h40);
		reg_write(`CFC_A_STAT, 8'he0);
		reg_check(`CFC_A_STAT, 8'hff, 8'h40);
		reg_write(`CFC_A_STAT, 8'h00);
		reg_check(`CFC_A_STAT, 8'hff, 8'h00);
		reg_check(3'h7, 8'hff, 8'h00);
		for (int h = 1; h >= 0; h--)
		begin
			@(posedge clock);
			core_status <= 8'h61;
			core_working_register <= 8'h72;
			core_bsr <= 4'h9;
			irq_high <= h[0];
			irq_req <= 1'b1;
			// The request is a single-clock pulse; holding it would raise a second one
			@(posedge clock);
			irq_req <= 1'b0;
			wait_ev(2, 1 - h);
			@(posedge clock);
			core_status <= 8'h0f;
			core_working_register <= 8'h0e;
			core_bsr <= 4'h1;
			wait_pm(h ? `CFC_VEC_HI : `CFC_VEC_LO);
			check(pm_addr_r, h ? `CFC_VEC_HI : `CFC_VEC_LO);
			repeat (24) @(negedge clock);
			check(restore_count, 2);
			check({restore_status_r, restore_working_register_r, restore_bsr_r}, 20'h61729);
		end
		reg_write(`CFC_A_TBL_L, 8'h05);
		u_pm.mem[0] = 16'h0008;
		repeat (16) @(negedge clock);
		reg_check(`CFC_A_TLAT, 8'hff, 8'hf1);
		reg_check(`CFC_A_TBL_L, 8'hff, 8'h05);
		reg_write(`CFC_A_CTRL, 8'h01);
		u_pm.mem[0] = 16'h0012;
		wait_ev(1, 0);
		check(rst_count, 1);
		reg_check(`CFC_A_STAT, 8'hdf, 8'h40);
		close_out();
	end

	// Whole run is a few hundred clocks; this margin only catches a hang
	initial
	begin
		repeat (20000) @(posedge clock);
		bad_count++;
		close_out();
	end
endmodule
`default_nettype wire
